// ===== hdl/io_port_pkg.sv
package io_port_pkg;
    localparam int NIB_W = 4;
    localparam int TWO_W = 2;
    localparam int BIT_PORT_W = 6;
    localparam int IDX_W = 4;
    localparam logic [NIB_W-1:0] NIB_RESET = 4'h0;
    localparam logic [BIT_PORT_W-1:0] BIT_PORT_RESET = 6'h3F;

    typedef enum logic [4:0] {
        OP_NONE = 5'h00, OP_IN_N0 = 5'h01, OP_OUT_N0 = 5'h02, OP_IN_N1 = 5'h03,
        OP_OUT_N1 = 5'h04, OP_IN_T0 = 5'h05, OP_OUT_T0 = 5'h06, OP_IN_T1 = 5'h07,
        OP_OUT_T1 = 5'h08, OP_BIT_ALL = 5'h09, OP_BIT_CLR = 5'h0A, OP_BIT_SET = 5'h0B,
        OP_BIT_TST = 5'h0C, OP_SB_SET = 5'h0D, OP_SB_CLR = 5'h0E, OP_SB_TST = 5'h0F,
        OP_IN_KEY = 5'h10, OP_OUT_KEY = 5'h11, OP_WK0_W = 5'h12, OP_WK0_R = 5'h13,
        OP_WK1_W = 5'h14, OP_WK1_R = 5'h15, OP_WK2_W = 5'h16, OP_WK2_R = 5'h17,
        OP_PU0_W = 5'h18, OP_PU1_W = 5'h19, OP_PU2_W = 5'h1A
    } io_op_t;

    typedef struct packed {
        logic valid;
        io_op_t op;
        logic [NIB_W-1:0] acc;
        logic [IDX_W-1:0] idx;
    } io_cmd_t;

    typedef struct packed {
        logic [NIB_W-1:0] wk0;
        logic [NIB_W-1:0] wk1;
        logic [NIB_W-1:0] wk2;
    } wake_regs_t;

    function automatic logic [NIB_W-1:0] zext2(input logic [TWO_W-1:0] v);
        zext2 = {{(NIB_W-TWO_W){1'b0}}, v};
    endfunction : zext2
endpackage : io_port_pkg

// ===== hdl/bit_port_unit.sv
`timescale 1ns/10ps
module bit_port_unit
    import io_port_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic en,
    input wire io_op_t op,
    input wire logic [IDX_W-1:0] idx,
    output logic [BIT_PORT_W-1:0] bits_reg,
    output logic test_zero
);
    // Out-of-range index leaves the port untouched and tests as one (no skip)
    localparam int SEL_W = $clog2(BIT_PORT_W);
    logic idx_ok;
    assign idx_ok = (idx < IDX_W'(BIT_PORT_W));
    assign test_zero = idx_ok && !bits_reg[idx[SEL_W-1:0]];

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            bits_reg <= BIT_PORT_RESET;
        end else if (en) begin
            case (op)
                OP_BIT_ALL: bits_reg <= {BIT_PORT_W{1'b1}};
                OP_BIT_CLR: if (idx_ok) bits_reg[idx[SEL_W-1:0]] <= 1'b0;
                OP_BIT_SET: if (idx_ok) bits_reg[idx[SEL_W-1:0]] <= 1'b1;
                default: ;
            endcase
        end
    end

    AST_CLR_ONE_BIT: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (en && op == OP_BIT_CLR && idx == 4'h2) |=> (bits_reg[2] == 1'b0 &&
        bits_reg[1:0] == $past(bits_reg[1:0]) && bits_reg[5:3] == $past(bits_reg[5:3])))
        else $error("bit clear wrong");
    AST_SET_ALL: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (en && op == OP_BIT_ALL) |=> bits_reg == 6'h3F) else $error("set all wrong");
endmodule : bit_port_unit

// ===== hdl/wake_pullup_regs.sv
`timescale 1ns/10ps
module wake_pullup_regs
    import io_port_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic en,
    input wire io_op_t op,
    input wire logic [NIB_W-1:0] acc,
    output wake_regs_t wake_reg,
    output logic [NIB_W-1:0] pu0_reg,
    output logic [NIB_W-1:0] pu1_reg,
    output logic [NIB_W-1:0] pu2_reg
);
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wake_reg <= '0;
        end else if (en) begin
            case (op)
                OP_WK0_W: wake_reg.wk0 <= acc;
                OP_WK1_W: wake_reg.wk1 <= acc;
                OP_WK2_W: wake_reg.wk2 <= acc;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pu0_reg <= NIB_RESET;
            pu1_reg <= NIB_RESET;
            pu2_reg <= NIB_RESET;
        end else if (en) begin
            case (op)
                OP_PU0_W: pu0_reg <= acc;
                OP_PU1_W: pu1_reg <= acc;
                OP_PU2_W: pu2_reg <= acc;
                default: ;
            endcase
        end
    end

    AST_WK1_LOAD: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (en && op == OP_WK1_W) |=> wake_reg.wk1 == $past(acc)) else $error("wk1 load");
    AST_PU2_LOAD: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (en && op == OP_PU2_W) |=> pu2_reg == $past(acc)) else $error("pu2 load");
endmodule : wake_pullup_regs

// ===== hdl/io_port_instruction_unit.sv
`timescale 1ns/10ps
module io_port_instruction_unit
    import io_port_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire io_cmd_t cmd,
    input wire logic [NIB_W-1:0] first_nibble_port_in,
    input wire logic [NIB_W-1:0] second_nibble_port_in,
    input wire logic [TWO_W-1:0] first_two_bit_port_in,
    input wire logic [TWO_W-1:0] second_two_bit_port_in,
    input wire logic key_port_in,
    output logic [NIB_W-1:0] first_nibble_port_reg,
    output logic [NIB_W-1:0] second_nibble_port_reg,
    output logic [TWO_W-1:0] first_two_bit_port_reg,
    output logic [TWO_W-1:0] second_two_bit_port_reg,
    output logic [BIT_PORT_W-1:0] bit_port_reg,
    output logic single_bit_port_reg,
    output logic key_port_reg,
    output logic acc_load_reg,
    output logic [NIB_W-1:0] acc_value_reg,
    output logic skip_reg,
    output logic [NIB_W-1:0] wakeup_control_reg_zero,
    output logic [NIB_W-1:0] wakeup_control_reg_one,
    output logic [NIB_W-1:0] wakeup_control_reg_two,
    output logic [NIB_W-1:0] pullup_control_reg_zero,
    output logic [NIB_W-1:0] pullup_control_reg_one,
    output logic [NIB_W-1:0] pullup_control_reg_two
);
    // The core still fetches and advances past a skipped instruction; we just drop its effects
    logic skip_pending_reg;
    logic exec;
    logic bit_test_zero;
    logic [NIB_W-1:0] acc_next;
    logic acc_load_next;
    wake_regs_t wake_regs;

    assign exec = cmd.valid && !skip_pending_reg;

    bit_port_unit u_bit_port (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .en(exec),
        .op(cmd.op),
        .idx(cmd.idx),
        .bits_reg(bit_port_reg),
        .test_zero(bit_test_zero)
    );

    wake_pullup_regs u_regs (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .en(exec),
        .op(cmd.op),
        .acc(cmd.acc),
        .wake_reg(wake_regs),
        .pu0_reg(pullup_control_reg_zero),
        .pu1_reg(pullup_control_reg_one),
        .pu2_reg(pullup_control_reg_two)
    );

    assign wakeup_control_reg_zero = wake_regs.wk0;
    assign wakeup_control_reg_one = wake_regs.wk1;
    assign wakeup_control_reg_two = wake_regs.wk2;

    always_comb begin
        acc_next = NIB_RESET;
        acc_load_next = 1'b1;
        case (cmd.op)
            OP_IN_N0: acc_next = first_nibble_port_in;
            OP_IN_N1: acc_next = second_nibble_port_in;
            OP_IN_T0: acc_next = zext2(first_two_bit_port_in);
            OP_IN_T1: acc_next = zext2(second_two_bit_port_in);
            OP_IN_KEY: acc_next = {{(NIB_W-1){1'b0}}, key_port_in};
            OP_WK0_R: acc_next = wake_regs.wk0;
            OP_WK1_R: acc_next = wake_regs.wk1;
            OP_WK2_R: acc_next = wake_regs.wk2;
            default: acc_load_next = 1'b0;
        endcase
    end

    // Accumulator result: the strobe is a pulse, the value holds until the next read
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            acc_load_reg <= 1'b0;
        end else begin
            acc_load_reg <= exec && acc_load_next;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            acc_value_reg <= NIB_RESET;
        end else if (exec && acc_load_next) begin
            acc_value_reg <= acc_next;
        end
    end

    AST_READ_N0: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (exec && cmd.op == OP_IN_N0) |=>
        (acc_load_reg && acc_value_reg == $past(first_nibble_port_in)))
        else $error("n0 read");

    AST_READ_N1: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (exec && cmd.op == OP_IN_N1) |=>
        (acc_load_reg && acc_value_reg == $past(second_nibble_port_in)))
        else $error("n1 read");

    AST_READ_T0: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (exec && cmd.op == OP_IN_T0) |=>
        (acc_load_reg && acc_value_reg == {2'h0, $past(first_two_bit_port_in)}))
        else $error("t0 read");

    AST_READ_T1: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (exec && cmd.op == OP_IN_T1) |=>
        (acc_value_reg[3:2] == 2'h0 && acc_value_reg[1:0] == $past(second_two_bit_port_in)))
        else $error("t1 read");

    AST_READ_KEY: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (exec && cmd.op == OP_IN_KEY) |=>
        (acc_load_reg && acc_value_reg == {3'h0, $past(key_port_in)}))
        else $error("key read");

    AST_WK0_READ: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (exec && cmd.op == OP_WK0_R) |=>
        (acc_load_reg && acc_value_reg == $past(wakeup_control_reg_zero)))
        else $error("wk0 read");

    AST_WK1_READ: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (exec && cmd.op == OP_WK1_R) |=>
        (acc_load_reg && acc_value_reg == $past(wakeup_control_reg_one)))
        else $error("wk1 read");

    AST_WK2_READ: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (exec && cmd.op == OP_WK2_R) |=>
        (acc_load_reg && acc_value_reg == $past(wakeup_control_reg_two)))
        else $error("wk2 read");

    AST_SKIP_NO_LOAD: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (skip_pending_reg && cmd.valid) |=> !acc_load_reg)
        else $error("skipped read loaded the accumulator");

    // Output latches, one per port; each holds until its own write comes
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            first_nibble_port_reg <= NIB_RESET;
        end else if (exec && cmd.op == OP_OUT_N0) begin
            first_nibble_port_reg <= cmd.acc;
        end
    end

    AST_WRITE_N0: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (exec && cmd.op == OP_OUT_N0) |=> first_nibble_port_reg == $past(cmd.acc))
        else $error("n0 write");
    AST_N0_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !(exec && cmd.op == OP_OUT_N0) |=> $stable(first_nibble_port_reg))
        else $error("n0 latch moved without a write");

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            second_nibble_port_reg <= NIB_RESET;
        end else if (exec && cmd.op == OP_OUT_N1) begin
            second_nibble_port_reg <= cmd.acc;
        end
    end

    AST_WRITE_N1: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (exec && cmd.op == OP_OUT_N1) |=> second_nibble_port_reg == $past(cmd.acc))
        else $error("n1 write");
    AST_N1_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !(exec && cmd.op == OP_OUT_N1) |=> $stable(second_nibble_port_reg))
        else $error("n1 latch moved without a write");

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            first_two_bit_port_reg <= '0;
        end else if (exec && cmd.op == OP_OUT_T0) begin
            first_two_bit_port_reg <= cmd.acc[TWO_W-1:0];
        end
    end

    AST_WRITE_T0: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (exec && cmd.op == OP_OUT_T0) |=> first_two_bit_port_reg == $past(cmd.acc[1:0]))
        else $error("t0 write");
    AST_T0_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !(exec && cmd.op == OP_OUT_T0) |=> $stable(first_two_bit_port_reg))
        else $error("t0 latch moved without a write");

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            second_two_bit_port_reg <= '0;
        end else if (exec && cmd.op == OP_OUT_T1) begin
            second_two_bit_port_reg <= cmd.acc[TWO_W-1:0];
        end
    end

    AST_WRITE_T1: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (exec && cmd.op == OP_OUT_T1) |=> second_two_bit_port_reg == $past(cmd.acc[1:0]))
        else $error("t1 write");

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            single_bit_port_reg <= 1'b0;
        end else if (exec && cmd.op == OP_SB_SET) begin
            single_bit_port_reg <= 1'b1;
        end else if (exec && cmd.op == OP_SB_CLR) begin
            single_bit_port_reg <= 1'b0;
        end
    end

    AST_SB_SET: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (exec && cmd.op == OP_SB_SET) |=> single_bit_port_reg == 1'b1)
        else $error("single bit set");
    AST_SB_CLR: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (exec && cmd.op == OP_SB_CLR) |=> single_bit_port_reg == 1'b0)
        else $error("single bit clear");
    AST_SB_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !(exec && (cmd.op == OP_SB_SET || cmd.op == OP_SB_CLR)) |=> $stable(single_bit_port_reg))
        else $error("single bit moved without a command");

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            key_port_reg <= 1'b0;
        end else if (exec && cmd.op == OP_OUT_KEY) begin
            key_port_reg <= cmd.acc[0];
        end
    end

    AST_KEY_WRITE: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (exec && cmd.op == OP_OUT_KEY) |=> key_port_reg == $past(cmd.acc[0]))
        else $error("key write");
    AST_KEY_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !(exec && cmd.op == OP_OUT_KEY) |=> $stable(key_port_reg))
        else $error("key latch moved without a write");

    // Checked at our own pins so that a miswired bundle shows up as well
    AST_WK0_WRITE: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (exec && cmd.op == OP_WK0_W) |=> wakeup_control_reg_zero == $past(cmd.acc))
        else $error("wk0 write");
    AST_WK1_WRITE: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (exec && cmd.op == OP_WK1_W) |=> wakeup_control_reg_one == $past(cmd.acc))
        else $error("wk1 write");
    AST_WK2_WRITE: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (exec && cmd.op == OP_WK2_W) |=> wakeup_control_reg_two == $past(cmd.acc))
        else $error("wk2 write");
    AST_PU0_WRITE: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (exec && cmd.op == OP_PU0_W) |=> pullup_control_reg_zero == $past(cmd.acc))
        else $error("pu0 write");
    AST_PU1_WRITE: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (exec && cmd.op == OP_PU1_W) |=> pullup_control_reg_one == $past(cmd.acc))
        else $error("pu1 write");
    AST_PU2_WRITE: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (exec && cmd.op == OP_PU2_W) |=> pullup_control_reg_two == $past(cmd.acc))
        else $error("pu2 write");

    // Skip decision: one pending skip swallows the next valid command
    localparam int SEL_W = $clog2(BIT_PORT_W);
    logic skip_now;
    logic bit_sel;
    assign skip_now = exec && ((cmd.op == OP_BIT_TST && bit_test_zero) ||
        (cmd.op == OP_SB_TST && single_bit_port_reg));
    assign bit_sel = bit_port_reg[cmd.idx[SEL_W-1:0]];

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            skip_reg <= 1'b0;
        end else begin
            skip_reg <= skip_now;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            skip_pending_reg <= 1'b0;
        end else if (skip_now) begin
            skip_pending_reg <= 1'b1;
        end else if (cmd.valid) begin
            skip_pending_reg <= 1'b0;
        end
    end

    AST_SB_TEST: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (exec && cmd.op == OP_SB_TST) |=> skip_reg == $past(single_bit_port_reg))
        else $error("single bit test");

    AST_BIT_TEST: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (exec && cmd.op == OP_BIT_TST && cmd.idx < IDX_W'(BIT_PORT_W)) |=>
        skip_reg == !$past(bit_sel))
        else $error("bit test");

    AST_SKIP_SUPPRESS: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (skip_pending_reg && cmd.valid && cmd.op == OP_OUT_N0) |=>
        $stable(first_nibble_port_reg)) else $error("skipped op took effect");

    AST_SKIP_ONE_CMD: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (skip_pending_reg && cmd.valid) |=> !skip_pending_reg)
        else $error("skip swallowed more than one command");

    // The bit port sits in its own unit; its effect is checked at our pins
    AST_BIT_SET: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (exec && cmd.op == OP_BIT_SET && cmd.idx < IDX_W'(BIT_PORT_W)) |=>
        bit_port_reg[$past(cmd.idx[SEL_W-1:0])] == 1'b1)
        else $error("bit set");

    AST_BIT_CLR: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (exec && cmd.op == OP_BIT_CLR && cmd.idx < IDX_W'(BIT_PORT_W)) |=>
        bit_port_reg[$past(cmd.idx[SEL_W-1:0])] == 1'b0)
        else $error("bit clear");
endmodule : io_port_instruction_unit

// ===== bench/pin_model.sv
`timescale 1ns/10ps
module pin_model
    import io_port_pkg::*;
(
    input wire logic [NIB_W-1:0] lvl,
    output logic [NIB_W-1:0] nib0,
    output logic [NIB_W-1:0] nib1,
    output logic [TWO_W-1:0] two0,
    output logic [TWO_W-1:0] two1,
    output logic key
);
    // Inverted copy on the second port catches swapped port wiring
    assign nib0 = lvl;
    assign nib1 = ~lvl;
    assign two0 = lvl[1:0];
    assign two1 = lvl[3:2];
    assign key = lvl[0];
endmodule : pin_model

// ===== bench/io_port_instruction_unit_bench.sv
`timescale 1ns/10ps
module io_port_instruction_unit_bench
    import io_port_pkg::*;
;
    logic clk_sys, reset_n, key_in, sb_q, key_q, ld_q, skip_q;
    io_cmd_t cmd;
    logic [NIB_W-1:0] lvl, n0_in, n1_in, n0_q, n1_q, acc_q, wk0, wk1, wk2, pu0, pu1, pu2;
    logic [TWO_W-1:0] t0_in, t1_in, t0_q, t1_q;
    logic [BIT_PORT_W-1:0] bp_q;
    int n_mismatch = 0;
    int total_checks = 0;

    pin_model pin_model_i (.lvl(lvl), .nib0(n0_in), .nib1(n1_in), .two0(t0_in),
        .two1(t1_in), .key(key_in));
    io_port_instruction_unit io_port_instruction_unit_i (.clk_sys(clk_sys),
        .reset_n(reset_n), .cmd(cmd), .first_nibble_port_in(n0_in),
        .second_nibble_port_in(n1_in), .first_two_bit_port_in(t0_in),
        .second_two_bit_port_in(t1_in), .key_port_in(key_in),
        .first_nibble_port_reg(n0_q), .second_nibble_port_reg(n1_q),
        .first_two_bit_port_reg(t0_q), .second_two_bit_port_reg(t1_q),
        .bit_port_reg(bp_q), .single_bit_port_reg(sb_q), .key_port_reg(key_q),
        .acc_load_reg(ld_q), .acc_value_reg(acc_q), .skip_reg(skip_q),
        .wakeup_control_reg_zero(wk0), .wakeup_control_reg_one(wk1),
        .wakeup_control_reg_two(wk2), .pullup_control_reg_zero(pu0),
        .pullup_control_reg_one(pu1), .pullup_control_reg_two(pu2));

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One command per call, then an idle cycle; outputs are settled on return
    task automatic issue(input io_op_t op, input logic [3:0] acc, input logic [3:0] idx);
        @(negedge clk_sys);
        cmd = '{1'b1, op, acc, idx};
        @(negedge clk_sys);
        cmd.valid = 1'b0;
    endtask : issue

    task automatic rd(input io_op_t op, input logic [3:0] exp);
        issue(op, 4'h0, 4'h0);
        chk({ld_q, acc_q}, {1'b1, exp});
    endtask : rd

    task automatic t_ports;
        lvl = 4'h9;
        rd(OP_IN_N0, 4'h9);
        rd(OP_IN_N1, 4'h6);
        rd(OP_IN_T0, 4'h1);
        rd(OP_IN_T1, 4'h2);
        rd(OP_IN_KEY, 4'h1);
        issue(OP_OUT_N0, 4'hC, 4'h0);
        chk(n0_q, 4'hC);
        issue(OP_OUT_N1, 4'h5, 4'h0);
        chk(n1_q, 4'h5);
        issue(OP_OUT_T0, 4'hE, 4'h0);
        chk(t0_q, 2'h2);
        issue(OP_OUT_T1, 4'h7, 4'h0);
        chk(t1_q, 2'h3);
        issue(OP_OUT_KEY, 4'h5, 4'h0);
        chk(key_q, 1'b1);
        issue(OP_OUT_KEY, 4'hA, 4'h0);
        chk(key_q, 1'b0);
        $display("t_ports done");
    endtask : t_ports

    task automatic t_bits;
        chk(bp_q, 6'h3F);
        issue(OP_BIT_CLR, 4'h0, 4'h5);
        chk(bp_q, 6'h1F);
        issue(OP_BIT_CLR, 4'h0, 4'h0);
        chk(bp_q, 6'h1E);
        issue(OP_BIT_SET, 4'h0, 4'h0);
        chk(bp_q, 6'h1F);
        issue(OP_BIT_ALL, 4'h0, 4'h0);
        chk(bp_q, 6'h3F);
        issue(OP_BIT_CLR, 4'h0, 4'h2);
        issue(OP_BIT_TST, 4'h0, 4'h3);
        chk(skip_q, 1'b0);
        issue(OP_BIT_TST, 4'h0, 4'h2);
        chk(skip_q, 1'b1);
        issue(OP_OUT_N0, 4'h3, 4'h0);
        chk(n0_q, 4'hC);
        issue(OP_OUT_N0, 4'h3, 4'h0);
        chk(n0_q, 4'h3);
        $display("t_bits done");
    endtask : t_bits

    task automatic t_single;
        issue(OP_SB_SET, 4'h0, 4'h0);
        chk(sb_q, 1'b1);
        issue(OP_SB_TST, 4'h0, 4'h0);
        chk(skip_q, 1'b1);
        issue(OP_IN_N0, 4'h0, 4'h0);
        chk(ld_q, 1'b0);
        issue(OP_SB_CLR, 4'h0, 4'h0);
        chk(sb_q, 1'b0);
        issue(OP_SB_TST, 4'h0, 4'h0);
        chk(skip_q, 1'b0);
        $display("t_single done");
    endtask : t_single

    task automatic t_regs;
        io_op_t wo[6] = '{OP_WK0_W, OP_WK1_W, OP_WK2_W, OP_PU0_W, OP_PU1_W, OP_PU2_W};
        for (int i = 0; i < 6; i++) begin
            issue(wo[i], 4'(i + 3), 4'h0);
        end
        chk({wk0, wk1, wk2}, 12'h345);
        chk({pu0, pu1, pu2}, 12'h678);
        rd(OP_WK0_R, 4'h3);
        rd(OP_WK1_R, 4'h4);
        rd(OP_WK2_R, 4'h5);
        $display("t_regs done");
    endtask : t_regs

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // About 35 commands of two cycles each plus 8 reset cycles; the 2000-cycle limit is over twenty times that
    initial begin
        #(2000 * 100);
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        reset_n = 1'b0;
        cmd = '0;
        lvl = 4'h0;
        repeat (8) @(negedge clk_sys);
        reset_n = 1'b1;
        chk({n0_q, wk0, pu2}, 12'h000);
        t_ports();
        t_bits();
        t_single();
        t_regs();
        tally_and_finish();
    end
endmodule : io_port_instruction_unit_bench
